// ==== design/srrd_pkg.sv ====
// package: opcodes, field codes, timing constants and carrier types for the decoder
package srrd_pkg;
    localparam logic [7:0] OP_REP_EQ = 8'hF3;
    localparam logic [7:0] OP_REP_NE = 8'hF2;
    localparam logic [6:0] OP_STRING_OUTPUT_HI = 7'h37;
    localparam logic [6:0] OP_STRING_STORE_HI = 7'h55;
    localparam logic [6:0] OP_STRING_COMPARE_HI = 7'h53;
    localparam logic [6:0] OP_STRING_SCAN_HI = 7'h57;
    localparam logic [7:0] OP_RET_NEAR = 8'hC3;
    localparam logic [7:0] OP_RET_NEAR_IMM = 8'hC2;
    localparam logic [7:0] OP_RET_FAR = 8'hCB;
    localparam logic [7:0] OP_RET_FAR_IMM = 8'hCA;
    localparam logic [6:0] OP_ROT_ONE_HI = 7'h68;
    localparam logic [6:0] OP_ROT_CNT_HI = 7'h69;
    localparam logic [6:0] OP_ROT_IMM_HI = 7'h60;
    localparam logic [2:0] REG_ROL = 3'h0;
    localparam logic [2:0] REG_RCL = 3'h2;
    localparam logic [2:0] REG_RCR = 3'h3;
    localparam logic [7:0] OP_PUSH_ALL = 8'h60;
    localparam logic [7:0] OP_PUSH_FLAGS = 8'h9C;
    localparam logic [7:0] OP_TWO_BYTE = 8'h0F;
    localparam logic [7:0] OP_READ_TSC = 8'h31;
    localparam logic [15:0] T_STRING_OUTPUT_REAL = 16'h0018;
    localparam logic [15:0] T_STRING_OUTPUT_PROT = 16'h0027;
    localparam logic [15:0] T_STRING_OUTPUT_ITER = 16'h0004;
    localparam logic [15:0] T_STRING_STORE_BASE = 16'h0009;
    localparam logic [15:0] T_STRING_STORE_ITER = 16'h0002;
    localparam logic [15:0] T_STRING_COMPARE_BASE = 16'h000B;
    localparam logic [15:0] T_STRING_COMPARE_ITER = 16'h0004;
    localparam logic [15:0] T_STRING_SCAN_BASE = 16'h0009;
    localparam logic [15:0] T_STRING_SCAN_ITER = 16'h0003;
    localparam logic [15:0] T_RET_NEAR = 16'h0003;
    localparam logic [15:0] T_RET_FAR_REAL = 16'h000A;
    localparam logic [15:0] T_RET_FAR_PROT = 16'h000D;
    localparam logic [15:0] T_RET_PRIV = 16'h0023;
    localparam logic [15:0] T_ROT = 16'h0002;
    localparam logic [15:0] T_ONE = 16'h0001;
    localparam logic [15:0] T_PUSH_ALL = 16'h000B;
    localparam logic [15:0] T_PUSH_FLAGS = 16'h0002;
    localparam logic [15:0] T_READ_TSC = 16'h0001;
    typedef enum logic [3:0] {
        OPK_NONE = 4'h0, OPK_STRING_OUTPUT = 4'h1, OPK_STRING_STORE = 4'h2, OPK_STRING_COMPARE = 4'h3,
        OPK_STRING_SCAN = 4'h4, OPK_RET_NEAR = 4'h5, OPK_RET_FAR = 4'h6,
        OPK_ROL = 4'h7, OPK_RCL = 4'h8, OPK_RCR = 4'h9, OPK_PUSH_ALL = 4'hA,
        OPK_PUSH_FLAGS = 4'hB, OPK_READ_TSC = 4'hC, OPK_ILLEGAL = 4'hD
    } srrd_kind_type;
    typedef struct packed {
        logic [7:0] prefix;
        logic [7:0] op0;
        logic [7:0] op1;
        logic [15:0] imm;
    } srrd_insn_type;
    typedef struct packed {
        srrd_kind_type kind;
        logic wide;
        logic rep_until_ne;
        logic adjust_sp;
        logic [1:0] rot_src;
        logic flags_touched;
        logic ovf_carry_only;
        logic repeated;
    } srrd_dec_type;
endpackage

// ==== design/srrd_decode.sv ====
// leaf decoder: classifies one instruction into kind and operand attributes
module srrd_decode
    import srrd_pkg::*;
(
    input wire srrd_insn_type insn_i,
    output srrd_dec_type dec_o
);
    wire rep_any = (insn_i.prefix == OP_REP_EQ) || (insn_i.prefix == OP_REP_NE);
    wire rep_ne = insn_i.prefix == OP_REP_NE;
    wire [6:0] hi7 = insn_i.op0[7:1];
    wire [2:0] reg_f = insn_i.op1[5:3];
    wire is_string_output = (insn_i.prefix == OP_REP_EQ) && (hi7 == OP_STRING_OUTPUT_HI);
    wire is_string_store = (insn_i.prefix == OP_REP_EQ) && (hi7 == OP_STRING_STORE_HI);
    wire is_string_compare = rep_any && (hi7 == OP_STRING_COMPARE_HI);
    wire is_string_scan = rep_any && (hi7 == OP_STRING_SCAN_HI);
    wire is_rnear = (insn_i.op0 == OP_RET_NEAR) || (insn_i.op0 == OP_RET_NEAR_IMM);
    wire is_rfar = (insn_i.op0 == OP_RET_FAR) || (insn_i.op0 == OP_RET_FAR_IMM);
    wire is_rot_grp = (hi7 == OP_ROT_ONE_HI) || (hi7 == OP_ROT_CNT_HI) || (hi7 == OP_ROT_IMM_HI);
    wire is_rol = is_rot_grp && (reg_f == REG_ROL);
    wire is_rcl = is_rot_grp && (reg_f == REG_RCL);
    wire is_rcr = is_rot_grp && (reg_f == REG_RCR);
    wire is_pa = insn_i.op0 == OP_PUSH_ALL;
    wire is_pf = insn_i.op0 == OP_PUSH_FLAGS;
    wire is_tsc = (insn_i.op0 == OP_TWO_BYTE) && (insn_i.op1 == OP_READ_TSC);
    srrd_kind_type kind;
    always_comb
    begin
        // string forms need their prefix; prefixed checks come first
        if (is_string_output) kind = OPK_STRING_OUTPUT;
        else if (is_string_store) kind = OPK_STRING_STORE;
        else if (is_string_compare) kind = OPK_STRING_COMPARE;
        else if (is_string_scan) kind = OPK_STRING_SCAN;
        else if (is_rnear) kind = OPK_RET_NEAR;
        else if (is_rfar) kind = OPK_RET_FAR;
        else if (is_rol) kind = OPK_ROL;
        else if (is_rcl) kind = OPK_RCL;
        else if (is_rcr) kind = OPK_RCR;
        else if (is_pa) kind = OPK_PUSH_ALL;
        else if (is_pf) kind = OPK_PUSH_FLAGS;
        else if (is_tsc) kind = OPK_READ_TSC;
        else kind = OPK_ILLEGAL;
    end
    assign dec_o.kind = kind;
    assign dec_o.wide = insn_i.op0[0];
    assign dec_o.rep_until_ne = rep_ne;
    assign dec_o.adjust_sp = (insn_i.op0 == OP_RET_NEAR_IMM) || (insn_i.op0 == OP_RET_FAR_IMM);
    assign dec_o.rot_src = (hi7 == OP_ROT_ONE_HI) ? 2'h0 : ((hi7 == OP_ROT_CNT_HI) ? 2'h1 : 2'h2);
    assign dec_o.flags_touched = is_string_compare || is_string_scan;
    assign dec_o.ovf_carry_only = is_rol || is_rcl || is_rcr;
    assign dec_o.repeated = is_string_output || is_string_store || is_string_compare || is_string_scan;
endmodule

// ==== design/srrd_core.sv ====
// execution-timing sequencer for repeated string, return, rotate, push and counter-read ops
////////////////////////////////////////////////////////////////////////////////
module srrd_core
    import srrd_pkg::*;
#(
    parameter int CNT_W = 32
)
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic issue_i,
    input wire srrd_insn_type insn_i,
    input wire logic prot_mode_i,
    input wire logic priv_change_i,
    input wire logic [CNT_W-1:0] count_i,
    input wire logic [31:0] elem_match_i,
    input wire logic [7:0] count_register_low_i,
    output logic busy_o,
    output logic done_o,
    output logic iter_o,
    output srrd_kind_type kind_o,
    output logic wide_o,
    output logic adjust_sp_o,
    output logic [15:0] sp_adjust_o,
    output logic [1:0] rot_src_o,
    output logic [7:0] rot_amount_o,
    output logic arith_flags_wr_o,
    output logic ovf_carry_wr_o,
    output logic [CNT_W-1:0] count_o,
    output logic [15:0] cycles_o,
    output logic [63:0] tsc_o,
    output logic illegal_o
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_BASE = 2'b01, ST_ITER = 2'b10, ST_DONE = 2'b11
    } srrd_state_type;
    srrd_state_type state;
    srrd_state_type next_state;
    srrd_dec_type dec;
    srrd_dec_type cur;
    logic [15:0] base_left;
    logic [15:0] next_base_left;
    logic [15:0] iter_left;
    logic [15:0] next_iter_left;
    logic [15:0] iter_cost;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [15:0] cycles;
    logic [63:0] tsc;

    srrd_decode u_decode
    (
        .insn_i(insn_i),
        .dec_o(dec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // fixed part of each instruction's cost, ready for the base phase
    logic [15:0] base_cost;
    always_comb
    begin
        case (dec.kind)
            OPK_STRING_OUTPUT: base_cost = prot_mode_i ? T_STRING_OUTPUT_PROT : T_STRING_OUTPUT_REAL;
            OPK_STRING_STORE: base_cost = T_STRING_STORE_BASE;
            OPK_STRING_COMPARE: base_cost = T_STRING_COMPARE_BASE;
            OPK_STRING_SCAN: base_cost = T_STRING_SCAN_BASE;
            OPK_RET_NEAR: base_cost = T_RET_NEAR;
            OPK_RET_FAR: base_cost = (prot_mode_i && priv_change_i) ? T_RET_PRIV
                : (prot_mode_i ? T_RET_FAR_PROT : T_RET_FAR_REAL);
            OPK_ROL: base_cost = T_ROT;
            OPK_RCL: base_cost = T_ROT;
            OPK_RCR: base_cost = T_ROT;
            OPK_PUSH_ALL: base_cost = T_PUSH_ALL;
            OPK_PUSH_FLAGS: base_cost = T_PUSH_FLAGS;
            OPK_READ_TSC: base_cost = T_READ_TSC;
            default: base_cost = T_ONE;
        endcase
    end

    logic [15:0] per_iter;
    always_comb
    begin
        case (dec.kind)
            OPK_STRING_OUTPUT: per_iter = T_STRING_OUTPUT_ITER;
            OPK_STRING_STORE: per_iter = T_STRING_STORE_ITER;
            OPK_STRING_COMPARE: per_iter = T_STRING_COMPARE_ITER;
            OPK_STRING_SCAN: per_iter = T_STRING_SCAN_ITER;
            default: per_iter = T_ONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare and scan: the element test decides whether a pass ends the loop
    wire elem_eq = (cur.wide ? elem_match_i : {24'h000000, elem_match_i[7:0]}) == 32'h00000000;
    wire stop_on_test = cur.flags_touched
        && (cur.rep_until_ne ? elem_eq : !elem_eq);
    wire cnt_zero = cnt == '0;
    wire base_end = base_left == T_ONE;
    wire iter_end = iter_left == T_ONE;
    wire start = issue_i && (state == ST_IDLE);

    always_comb
    begin
        next_state = state;
        next_base_left = base_left;
        next_iter_left = iter_left;
        next_cnt = cnt;
        case (state)
            ST_IDLE:
            begin
                if (issue_i)
                begin
                    // done is the last cycle of the cost, so the base phase runs one short
                    next_state = (base_cost == T_ONE) ? ST_DONE : ST_BASE;
                    next_base_left = base_cost - T_ONE;
                    next_iter_left = per_iter;
                    next_cnt = dec.repeated ? count_i : '0;
                end
            end
            ST_BASE:
            begin
                next_base_left = base_left - T_ONE;
                if (base_end)
                    next_state = (cur.repeated && !cnt_zero) ? ST_ITER : ST_DONE;
            end
            ST_ITER:
            begin
                next_iter_left = iter_left - T_ONE;
                if (iter_end)
                begin
                    // each pass decrements the count; cnt holds the passes still to run
                    next_cnt = cnt - CNT_W'(1);
                    next_iter_left = iter_cost;
                    if ((cnt == CNT_W'(1)) || stop_on_test)
                        next_state = ST_DONE;
                end
            end
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state <= ST_IDLE;
            base_left <= 16'h0000;
            iter_left <= 16'h0000;
            iter_cost <= 16'h0000;
            cnt <= '0;
            cur <= '0;
        end
        else
        begin
            state <= next_state;
            base_left <= next_base_left;
            iter_left <= next_iter_left;
            cnt <= next_cnt;
            if (start)
            begin
                cur <= dec;
                iter_cost <= per_iter;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cycle and time-stamp counters; the stamp runs free from reset
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cycles <= 16'h0000;
            tsc <= 64'h0000000000000000;
        end
        else
        begin
            tsc <= tsc + 64'h0000000000000001;
            // the issue cycle counts, so a finished op shows its full cost at done
            if (start)
                cycles <= T_ONE;
            else if (state == ST_BASE || state == ST_ITER)
                cycles <= cycles + T_ONE;
        end
    end

    // latched results, captured at the start for stable sideband outputs
    logic [63:0] tsc_hold;
    logic [15:0] imm_hold;
    logic [7:0] rot_amt;
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tsc_hold <= 64'h0000000000000000;
            imm_hold <= 16'h0000;
            rot_amt <= 8'h00;
        end
        else if (start)
        begin
            if (dec.kind == OPK_READ_TSC)
                tsc_hold <= tsc;
            imm_hold <= dec.adjust_sp ? insn_i.imm : 16'h0000;
            rot_amt <= (dec.rot_src == 2'h0) ? 8'h01
                : ((dec.rot_src == 2'h1) ? count_register_low_i : insn_i.imm[7:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign busy_o = state != ST_IDLE;
    assign done_o = state == ST_DONE;
    assign iter_o = (state == ST_ITER) && iter_end;
    assign kind_o = cur.kind;
    assign wide_o = cur.wide;
    assign adjust_sp_o = cur.adjust_sp;
    assign sp_adjust_o = imm_hold;
    assign rot_src_o = cur.rot_src;
    assign rot_amount_o = rot_amt;
    // flag writes only for compare/scan and rotates; string out/store, returns, pushes keep flags
    assign arith_flags_wr_o = done_o && cur.flags_touched;
    assign ovf_carry_wr_o = done_o && cur.ovf_carry_only;
    assign count_o = cnt;
    assign cycles_o = cycles;
    assign tsc_o = tsc_hold;
    assign illegal_o = cur.kind == OPK_ILLEGAL;

    ////////////////////////////////////////////////////////////////////////////
    property p_ret_near_time;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (start && dec.kind == OPK_RET_NEAR) |-> ##3 done_o;
    endproperty
    a_ret_near_time: assert property (p_ret_near_time) else $error("near return not 3 cycles");

    property p_ret_real_time;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        // idle run split in two keeps each repetition short for the tools
        (start && dec.kind == OPK_RET_FAR && !prot_mode_i)
            |-> !done_o [*5] ##1 !done_o [*5] ##1 done_o;
    endproperty
    a_ret_real_time: assert property (p_ret_real_time) else $error("far return not 10 cycles");

    property p_ret_priv_time;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (start && dec.kind == OPK_RET_FAR && prot_mode_i && priv_change_i) |-> ##35 done_o;
    endproperty
    a_ret_priv_time: assert property (p_ret_priv_time) else $error("privilege return not 35");

    property p_rot_time;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (start && dec.kind == OPK_ROL) |-> ##2 (done_o && ovf_carry_wr_o && !arith_flags_wr_o);
    endproperty
    a_rot_time: assert property (p_rot_time) else $error("rotate left timing or flags wrong");

    property p_rcl_flags;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (done_o && (kind_o == OPK_RCL || kind_o == OPK_RCR)) |-> ovf_carry_wr_o;
    endproperty
    a_rcl_flags: assert property (p_rcl_flags) else $error("carry rotate skipped flags");

    property p_string_store_noflags;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (done_o && kind_o == OPK_STRING_STORE) |-> !arith_flags_wr_o && !ovf_carry_wr_o;
    endproperty
    a_string_store_noflags: assert property (p_string_store_noflags) else $error("string store wrote flags");

    property p_count_dec;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        iter_o |=> (count_o == $past(count_o) - CNT_W'(1));
    endproperty
    a_count_dec: assert property (p_count_dec) else $error("count not decremented per pass");

    property p_string_compare_stop;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (iter_o && cur.kind == OPK_STRING_COMPARE && stop_on_test) |=> done_o;
    endproperty
    a_string_compare_stop: assert property (p_string_compare_stop) else $error("compare did not stop");

    property p_flags_out_keep;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (done_o && (kind_o == OPK_STRING_OUTPUT || kind_o == OPK_PUSH_FLAGS)) |-> !arith_flags_wr_o;
    endproperty
    a_flags_out_keep: assert property (p_flags_out_keep) else $error("flags changed");
endmodule

// ==== tb/srrd_fetch_model.sv ====
// partner model: memory side that supplies element comparison results per pass
module srrd_fetch_model
    import srrd_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic iter_i,
    input wire logic done_i,
    input wire logic [7:0] stop_pass_i,
    input wire logic until_equal_i,
    input wire logic byte_i,
    output logic [31:0] elem_match_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] passes;
    logic [31:0] stop_val;
    logic [31:0] go_val;
    ////////////////////////////////////////////////////////////////////////////
    // pass counter, cleared at the end of each instruction
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            passes <= 8'h00;
        else if (done_i)
            passes <= 8'h00;
        else if (iter_i)
            passes <= passes + 8'h01;
    end
    ////////////////////////////////////////////////////////////////////////////
    // byte forms get junk above bit 7 so only the low byte may decide
    assign stop_val = until_equal_i ? (byte_i ? 32'hFFFFFF00 : 32'h00000000) : 32'h0000005A;
    assign go_val = until_equal_i ? 32'h000000C3 : (byte_i ? 32'hFFFFFF00 : 32'h00000000);
    assign elem_match_o = (passes + 8'h01 == stop_pass_i) ? stop_val : go_val;
endmodule

// ==== tb/string_repeat_return_rotate_decode_tb.sv ====
// self-checking bench for the decode and timing sequencer
module string_repeat_return_rotate_decode_tb
    import srrd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic issue_i = 1'b0;
    srrd_insn_type insn_i = '0;
    logic prot_mode_i = 1'b0;
    logic priv_change_i = 1'b0;
    logic [31:0] count_i = 32'h0;
    logic [7:0] crl = 8'h05;
    logic [7:0] stop_pass = 8'h00;
    logic until_eq = 1'b0;
    logic byte_sel = 1'b0;
    wire [31:0] elem;
    logic busy_o, done_o, iter_o, wide_o, adjust_sp_o, arith_flags_wr_o, ovf_carry_wr_o, illegal_o;
    srrd_kind_type kind_o;
    logic [15:0] sp_adjust_o;
    logic [15:0] cycles_o;
    logic [1:0] rot_src_o;
    logic [7:0] rot_amount_o;
    logic [31:0] count_o;
    logic [63:0] tsc_o;
    logic [63:0] cyc = 64'h0;
    logic [63:0] take_cyc;
    int fail_count = 0;
    int samples_checked = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) cyc <= cyc + 64'h1;
    srrd_core #(.CNT_W(32)) u_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .issue_i(issue_i),
        .insn_i(insn_i), .prot_mode_i(prot_mode_i), .priv_change_i(priv_change_i),
        .count_i(count_i), .elem_match_i(elem), .count_register_low_i(crl), .busy_o(busy_o),
        .done_o(done_o), .iter_o(iter_o), .kind_o(kind_o), .wide_o(wide_o),
        .adjust_sp_o(adjust_sp_o), .sp_adjust_o(sp_adjust_o), .rot_src_o(rot_src_o),
        .rot_amount_o(rot_amount_o), .arith_flags_wr_o(arith_flags_wr_o),
        .ovf_carry_wr_o(ovf_carry_wr_o), .count_o(count_o), .cycles_o(cycles_o), .tsc_o(tsc_o),
        .illegal_o(illegal_o));
    srrd_fetch_model u_mem (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .iter_i(iter_o),
        .done_i(done_o), .stop_pass_i(stop_pass), .until_equal_i(until_eq),
        .byte_i(byte_sel), .elem_match_o(elem));
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checked %0d mismatched %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic hang(input string what);
        fail_count++;
        $display("Error %s expected done seen timeout", what);
        tally_and_finish();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // one instruction: wait idle, offer it for one edge, count busy cycles to done
    task automatic run(input logic [7:0] pf, input logic [7:0] o0, input logic [7:0] o1,
        input logic [15:0] imm, input logic pm, input logic pc, input logic [31:0] cnt,
        input logic [15:0] cost, input srrd_kind_type k, input logic [1:0] fl,
        input logic [31:0] rem);
        logic [15:0] c;
        int i;
        i = 0;
        while (busy_o !== 1'b0 && i < 300)
        begin
            @(negedge sys_clk_i);
            i++;
        end
        if (i >= 300)
            hang("idle");
        insn_i = '{prefix: pf, op0: o0, op1: o1, imm: imm};
        prot_mode_i = pm;
        priv_change_i = pc;
        count_i = cnt;
        issue_i = 1'b1;
        @(negedge sys_clk_i);
        issue_i = 1'b0;
        take_cyc = cyc;
        c = 16'h1;
        i = 0;
        while (done_o !== 1'b1 && i < 300)
        begin
            @(negedge sys_clk_i);
            c++;
            i++;
        end
        if (i >= 300)
            hang("done");
        check("cycles", 64'(c), 64'(cost));
        check("cycles_o", 64'(cycles_o), 64'(cost));
        check("kind", 64'(kind_o), 64'(k));
        check("arith_flags_wr", 64'(arith_flags_wr_o), 64'(fl[1]));
        check("ovf_carry_wr", 64'(ovf_carry_wr_o), 64'(fl[0]));
        check("illegal", 64'(illegal_o), 64'(k == OPK_ILLEGAL));
        if (k inside {OPK_STRING_OUTPUT, OPK_STRING_STORE, OPK_STRING_COMPARE, OPK_STRING_SCAN})
            check("count", 64'(count_o), 64'(rem));
        if (k inside {OPK_STRING_OUTPUT, OPK_STRING_STORE, OPK_STRING_COMPARE, OPK_STRING_SCAN, OPK_ROL, OPK_RCL, OPK_RCR})
            check("wide", 64'(wide_o), 64'(o0[0]));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [63:0] t1;
        logic [63:0] c1;
        srrd_kind_type rk;
        logic [7:0] amt;
        repeat (6) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rstn_i = 1'b1;
        for (int m = 0; m < 2; m++)
        begin
            run(8'h00, 8'hC3, 8'h00, 16'h0, m[0], 1'b0, 0, 3, OPK_RET_NEAR, 2'b00, 0);
            run(8'h00, 8'hC2, 8'h00, 16'h1234, m[0], 1'b0, 0, 3, OPK_RET_NEAR, 2'b00, 0);
            check("sp_adjust", 64'({adjust_sp_o, sp_adjust_o}), 64'h11234);
            run(8'h00, 8'hCB, 8'h00, 16'h0, m[0], 1'b0, 0, m[0] ? 13 : 10, OPK_RET_FAR, 2'b00, 0);
            run(8'h00, 8'hCA, 8'h00, 16'h0040, m[0], 1'b1, 0, m[0] ? 35 : 10, OPK_RET_FAR, 2'b00, 0);
            check("sp_adjust", 64'(sp_adjust_o), 64'h0040);
            run(8'hF3, 8'h6E, 8'h00, 16'h0, m[0], 1'b0, 3, m[0] ? 39 + 12 : 24 + 12, OPK_STRING_OUTPUT, 2'b00, 0);
            run(8'hF3, 8'hAB, 8'h00, 16'h0, m[0], 1'b0, 5, 9 + 10, OPK_STRING_STORE, 2'b00, 0);
        end
        run(8'h00, 8'hCB, 8'h00, 16'h0, 1'b1, 1'b1, 0, 35, OPK_RET_FAR, 2'b00, 0);
        run(8'hF3, 8'h6F, 8'h00, 16'h0, 1'b0, 1'b0, 0, 24, OPK_STRING_OUTPUT, 2'b00, 0);
        run(8'hF3, 8'hAA, 8'h00, 16'h0, 1'b1, 1'b0, 0, 9, OPK_STRING_STORE, 2'b00, 0);
        until_eq = 1'b0;
        stop_pass = 8'h02;
        run(8'hF3, 8'hA7, 8'h00, 16'h0, 1'b0, 1'b0, 6, 11 + 8, OPK_STRING_COMPARE, 2'b10, 4);
        stop_pass = 8'h00;
        byte_sel = 1'b1;
        run(8'hF3, 8'hAE, 8'h00, 16'h0, 1'b1, 1'b0, 4, 9 + 12, OPK_STRING_SCAN, 2'b10, 0);
        until_eq = 1'b1;
        stop_pass = 8'h03;
        run(8'hF2, 8'hA6, 8'h00, 16'h0, 1'b0, 1'b0, 5, 11 + 12, OPK_STRING_COMPARE, 2'b10, 2);
        byte_sel = 1'b0;
        stop_pass = 8'h01;
        run(8'hF2, 8'hAF, 8'h00, 16'h0, 1'b1, 1'b0, 7, 9 + 3, OPK_STRING_SCAN, 2'b10, 6);
        for (int f = 0; f < 3; f++)
        begin
            rk = (f == 0) ? OPK_ROL : (f == 1) ? OPK_RCL : OPK_RCR;
            for (int s = 0; s < 3; s++)
            begin
                crl = 8'h07 + 8'(f);
                amt = (s == 0) ? 8'h01 : (s == 1) ? crl : 8'h13;
                run(8'h00, {(s == 2) ? 4'hC : 4'hD, 2'b00, s == 1, s[0]},
                    {2'b11, (f == 0) ? REG_ROL : (f == 1) ? REG_RCL : REG_RCR, 3'h1},
                    16'h0013, f[0], 1'b0, 0, 2, rk, 2'b01, 0);
                check("rot_src", 64'(rot_src_o), 64'(s));
                check("rot_amount", 64'(rot_amount_o), 64'(amt));
            end
        end
        run(8'h00, 8'h60, 8'h00, 16'h0, 1'b0, 1'b0, 0, 11, OPK_PUSH_ALL, 2'b00, 0);
        run(8'h00, 8'h9C, 8'h00, 16'h0, 1'b1, 1'b0, 0, 2, OPK_PUSH_FLAGS, 2'b00, 0);
        run(8'h00, 8'h0F, 8'h31, 16'h0, 1'b0, 1'b0, 0, 1, OPK_READ_TSC, 2'b00, 0);
        t1 = tsc_o;
        c1 = take_cyc;
        repeat (9) @(negedge sys_clk_i);
        run(8'h00, 8'h0F, 8'h31, 16'h0, 1'b1, 1'b0, 0, 1, OPK_READ_TSC, 2'b00, 0);
        check("tsc_delta", tsc_o - t1, take_cyc - c1);
        // the repeat-while-unequal prefix has no store form, so it must be refused
        run(8'hF2, 8'hAA, 8'h00, 16'h0, 1'b0, 1'b0, 2, 1, OPK_ILLEGAL, 2'b00, 0);
        tally_and_finish();
    end
endmodule
